// File: adc_gain_pkg.sv
`default_nettype none

package adc_gain_pkg;

  localparam int REG_ADDR_W = 8;
  localparam int GAIN_W = 12;

  // special function register addresses of the host-side ports
  localparam logic [7:0] RESULT_LOW_ADDR = 8'hbd;
  localparam logic [7:0] RESULT_HIGH_ADDR = 8'hbe;
  localparam logic [7:0] ADC_CONFIG_ADDR = 8'hbc;

  // indirect gain register indices
  localparam logic [7:0] GAIN_HIGH_IDX = 8'h04;
  localparam logic [7:0] GAIN_LOW_IDX = 8'h07;
  localparam logic [7:0] GAIN_ADD_IDX = 8'h08;

  // field positions
  localparam int ACCESS_EN_BIT = 0;
  localparam int OFFSET_ADD_BIT = 0;
  localparam int LOW_NIBBLE_LSB = 4;

  // reset values
  localparam logic [7:0] GAIN_HIGH_RST = 8'hfc;
  localparam logic [7:0] GAIN_LOW_RST = 8'h00;
  localparam logic GAIN_ADD_RST = 1'b1;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] INDEX_RST = 8'h00;

  // index register has 3 meaningful slots; beyond is ignored
  localparam int GAIN_SLOTS = 3;

  typedef enum logic [1:0] {
    SLOT_HIGH,
    SLOT_LOW,
    SLOT_ADD,
    SLOT_NONE
  } gain_slot_type;

endpackage : adc_gain_pkg

`default_nettype wire

// File: gain_reg_store.sv
`default_nettype none

module gain_reg_store
  import adc_gain_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire gain_slot_type wr_slot_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] gain_high_o,
  output logic [7:0] gain_low_o,
  output logic gain_add_o
);

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
    logic add;
  } store_type;

  store_type st_ff;
  store_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_en_i)
    begin
      unique case (wr_slot_i)
        SLOT_HIGH: nxt_st.high = wr_data_i;
        SLOT_LOW: nxt_st.low = wr_data_i;
        SLOT_ADD: nxt_st.add = wr_data_i[OFFSET_ADD_BIT];
        SLOT_NONE: nxt_st = st_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= '{high: GAIN_HIGH_RST, low: GAIN_LOW_RST, add: GAIN_ADD_RST};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign gain_high_o = st_ff.high;
  assign gain_low_o = st_ff.low;
  assign gain_add_o = st_ff.add;

endmodule // gain_reg_store

`default_nettype wire

// File: adc_gain_indirect_regs.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - gain word is high byte then low register bits 7..4.
// - effective gain is word/4096 plus 1/64 when offset-add set.
// - access-enable bit 0 of config steers result ports to gain regs.
// - high-port write selects gain register; low-port write loads data.
// - gain registers are write-only; reads never return their contents.
// - indices 0x04 high byte, 0x07 low nibble, 0x08 offset-add.
module adc_gain_indirect_regs
  import adc_gain_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] conv_result_i,
  output logic gain_access_enable_o,
  output logic [GAIN_W-1:0] gain_word_o,
  output logic gain_offset_add_o,
  output logic [GAIN_W:0] gain_scaled_o
);

  typedef struct packed {
    logic [7:0] config_reg;
    logic [7:0] index;
    logic [7:0] rdata;
  } state_type;

  state_type st_ff;
  state_type nxt_st;
  logic access_en;
  logic store_wr;
  gain_slot_type slot;
  logic [7:0] gh;
  logic [7:0] gl;
  logic ga;

  ////////////////////////////////////////////////////////////////////////////
  // index decode
  function automatic gain_slot_type decode_index(input logic [7:0] idx);
    gain_slot_type s;
    s = SLOT_NONE;
    if (idx == GAIN_HIGH_IDX)
      s = SLOT_HIGH;
    else if (idx == GAIN_LOW_IDX)
      s = SLOT_LOW;
    else if (idx == GAIN_ADD_IDX)
      s = SLOT_ADD;
    return s;
  endfunction

  assign access_en = st_ff.config_reg[ACCESS_EN_BIT];
  assign slot = decode_index(st_ff.index);
  assign store_wr = access_en && reg_wr_i && (reg_addr_i == RESULT_LOW_ADDR)
                    && (slot != SLOT_NONE);

  gain_reg_store u_store (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(store_wr),
    .wr_slot_i(slot),
    .wr_data_i(reg_wdata_i),
    .gain_high_o(gh),
    .gain_low_o(gl),
    .gain_add_o(ga)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st = st_ff;
    if (reg_wr_i)
    begin
      if (reg_addr_i == ADC_CONFIG_ADDR)
        nxt_st.config_reg = reg_wdata_i;
      else if (access_en && reg_addr_i == RESULT_HIGH_ADDR)
        nxt_st.index = reg_wdata_i;
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        ADC_CONFIG_ADDR: nxt_st.rdata = st_ff.config_reg;
        // in gain mode high port reads back the index and low port reads zero; result otherwise
        RESULT_HIGH_ADDR:
          nxt_st.rdata = access_en ? st_ff.index : conv_result_i[15:8];
        RESULT_LOW_ADDR:
          nxt_st.rdata = access_en ? 8'h00 : conv_result_i[7:0];
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= '{config_reg: CONFIG_RST, index: INDEX_RST, rdata: 8'h00};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata_o = st_ff.rdata;
  assign gain_access_enable_o = access_en;
  assign gain_word_o = {gh, gl[7:LOW_NIBBLE_LSB]};
  assign gain_offset_add_o = ga;
  // gain in 1/4096 units; 1/64 is 64 units
  assign gain_scaled_o = {1'b0, gain_word_o} + (ga ? 13'h0040 : 13'h0000);

endmodule // adc_gain_indirect_regs

`default_nettype wire

// File: adc_gain_properties.sv
`default_nettype none
module adc_gain_properties import adc_gain_pkg::*; (
  input wire logic sys_clk_i, reset_n_i, reg_wr_i, reg_rd_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
  input wire logic [15:0] conv_result_i,
  input wire logic gain_access_enable_o, gain_offset_add_o,
  input wire logic [11:0] gain_word_o,
  input wire logic [12:0] gain_scaled_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire en = gain_access_enable_o;
  wire [12:0] g = {gain_word_o, gain_offset_add_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // last index written to the address port, so data-port writes can be judged
  logic [7:0] idx_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
    if (!reset_n_i)
      idx_q <= 8'h00;
    else if (reg_wr_i && en && reg_addr_i == RESULT_HIGH_ADDR)
      idx_q <= reg_wdata_i;
  wire dp = reg_wr_i && en && reg_addr_i == RESULT_LOW_ADDR;
  a_high_load: assert property (dp && idx_q == GAIN_HIGH_IDX
    |=> gain_word_o[11:4] == $past(reg_wdata_i)) else $error("high load");
  a_bad_index: assert property (dp && idx_q != GAIN_HIGH_IDX &&
    idx_q != GAIN_LOW_IDX && idx_q != GAIN_ADD_IDX |=> $stable(g))
    else $error("bad index");
  a_sum_ok: assert property (gain_scaled_o == g[12:1] + 64 * g[0])
    else $error("sum");
  a_en_set: assert property (reg_wr_i && reg_addr_i == ADC_CONFIG_ADDR
    |=> en == $past(reg_wdata_i[0])) else $error("en");
  a_gain_kept: assert property (reg_wr_i && !en |=> $stable(g))
    else $error("kept");
  a_no_peek: assert property (reg_rd_i && en && reg_addr_i ==
    RESULT_LOW_ADDR |=> reg_rdata_o == 8'h00) else $error("peek");
  c_cfg: cover property (reg_wr_i && en);
  c_peek: cover property (reg_rd_i && en);
  c_conv: cover property (reg_rd_i && !en);
endmodule // adc_gain_properties
`default_nettype wire

// File: adc_gain_indirect_regs_tb_top.sv
`default_nettype none
module adc_gain_indirect_regs_tb_top import adc_gain_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, wq, rq;
  logic en = 0, ga = 1, gain_access_enable_o, gain_offset_add_o;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, gh = 8'hfc;
  logic [7:0] gl = 0, ix = 0;
  logic [15:0] conv_result_i = 0, q[$];
  logic [11:0] gain_word_o;
  logic [12:0] gain_scaled_o;
  logic [12:0] sq[$];
  wire [15:0] gain_obs = {2'b0, gain_access_enable_o, gain_offset_add_o,
    gain_word_o};
  int error_cnt = 0, compares = 0, cyc = 0, seed = 32'h6a1a9bd3;
  always #5 sys_clk_i = ~sys_clk_i;
  adc_gain_indirect_regs u_dut (.*);
  task automatic cmp(string n, logic [15:0] e, g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // model notes what each access should leave behind
  task automatic op(bit r, logic [7:0] ad, dt);
    bit w;
    {reg_addr_i, reg_wdata_i, reg_rd_i, reg_wr_i} = {ad, dt, r, !r};
    // result input only moves while gain access is off
    if (!en)
      conv_result_i = 16'($random(seed));
    if (r)
      q.push_back({8'h0, ad == RESULT_HIGH_ADDR ? (en ? ix :
        conv_result_i[15:8]) : ad == RESULT_LOW_ADDR && !en ?
        conv_result_i[7:0] : 8'h0});
    else
    begin
      en = ad == ADC_CONFIG_ADDR ? dt[0] : en;
      ix = en && ad == RESULT_HIGH_ADDR ? dt : ix;
      w = en && ad == RESULT_LOW_ADDR;
      gh = w && ix == 8'h04 ? dt : gh;
      gl = w && ix == 8'h07 ? dt : gl;
      ga = w && ix == 8'h08 ? dt[0] : ga;
      q.push_back({2'b0, en, ga, gh, gl[7:4]});
      sq.push_back(13'({gh, gl[7:4]}) + (ga ? 13'h0040 : 13'h0000));
    end
    @(posedge sys_clk_i);
    #1 {reg_wr_i, reg_rd_i} = 2'b0;
    // idle cycle so a strobe is never dropped and raised in one step
    @(posedge sys_clk_i) #1;
  endtask
  always @(posedge sys_clk_i)
  begin
    {wq, rq} <= {reg_wr_i, reg_rd_i};
    if (++cyc == 900)
    begin
      error_cnt++;
      close_out;
    end
  end
  always @(negedge sys_clk_i)
    if (rq)
      cmp("rdata", q.pop_front(), {8'h0, reg_rdata_o});
    else if (wq)
    begin
      cmp("gain", q.pop_front(), gain_obs);
      cmp("scaled", 16'(sq.pop_front()), 16'(gain_scaled_o));
    end
  initial
  begin
    repeat (6) @(posedge sys_clk_i) #1;
    reset_n_i = 1;
    op(0, ADC_CONFIG_ADDR, 8'h01);
    for (int i = 0; i < 12; i++)
    begin
      op(0, RESULT_HIGH_ADDR, 8'h04 + 8'(i % 6));
      op(0, RESULT_LOW_ADDR, 8'($random(seed)));
      op(1, RESULT_LOW_ADDR, 8'h00);
    end
    $display("test gain mode done");
    op(0, ADC_CONFIG_ADDR, 8'h00);
    op(0, RESULT_LOW_ADDR, 8'h5a);
    op(1, RESULT_LOW_ADDR, 8'h00);
    op(1, 8'h55, 8'h00);
    $display("test normal mode done");
    close_out;
  end
endmodule // adc_gain_indirect_regs_tb_top
bind adc_gain_indirect_regs adc_gain_properties u_props (.*);
`default_nettype wire
